// ==== logic/sdcke_pkg.sv ====
// Purpose: Shared constants for the DDR2 command and CKE tracker
// Assumes: 100 MHz sys_clk
// Notes: Clock period in ns; wait and lock times given directly in clock cycles
package sdcke_pkg;

    // Command decode on (rasN, casN, weN)
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_MRS = 3'h0;

    // Mode register select on bank address
    localparam logic [1:0] BA_MR = 2'h0;
    localparam logic [1:0] BA_EMR = 2'h1;

    localparam int CLK_PERIOD_NS = 10;
    // Least wait after CKE low before clock change
    localparam int FREQ_WAIT_CLK = 2;
    // DLL lock time, clocks
    localparam int DLL_LOCK_CLK = 200;
    localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CLK);
    localparam logic [1:0] FREQ_WAIT_CNT = 2'(FREQ_WAIT_CLK);

    // Burst length fixed at reset, in command cycles (BL/2)
    localparam logic [2:0] BURST_CYC_RST = 3'h4;
    // DLL reset bit position in EMRS address word
    localparam int DLL_RST_BIT = 8;

    typedef enum logic [2:0]
    {
        ST_RUN = 3'b000,
        ST_PWRDN = 3'b001,
        ST_LOST = 3'b010,
        ST_REINIT = 3'b011,
        ST_RELOCK = 3'b100
    } sdcke_state_t;

endpackage

// ==== logic/sdcke_tracker.sv ====
// Purpose: Device-side command decode and CKE / clock-change tracking
// Assumes: Pins pass a two-stage synchroniser; one clock only
// Notes: Models state of the memory, not the array itself
`timescale 1ns/10ps

module sdcke_tracker
(
    input wire logic sys_clk, // 100 MHz clock
    input wire logic resetn, // Sync reset, active low
    input wire logic ckePin, // Clock enable pin
    input wire logic csN, // Chip select, active low
    input wire logic rasN, // Row strobe, active low
    input wire logic casN, // Column strobe, active low
    input wire logic weN, // Write enable, active low
    input wire logic [1:0] bankAddr, // Bank address
    input wire logic [12:0] addr, // Address bus
    input wire logic initDone, // Init steps complete
    input wire logic allBanksIdle, // No row open
    output logic dataLost, // Array contents not guaranteed
    output logic ready, // Normal operation allowed
    output logic pwrDown, // In precharge power-down
    output logic freqChangeOk, // Clock may now change
    output logic dllLocked, // DLL has relocked
    output logic burstBusy, // Burst in progress
    output logic nopSeen // NOP or deselect registered
);

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [6:0] syncA_reg, syncB_reg;
    logic cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0] baS_reg, baQ_reg;
    logic [12:0] adS_reg, adQ_reg;

    always_ff @(posedge sys_clk)
    begin
        syncA_reg <= {ckePin, csN, rasN, casN, weN, initDone, allBanksIdle};
        syncB_reg <= syncA_reg;
        baS_reg <= bankAddr;
        baQ_reg <= baS_reg;
        adS_reg <= addr;
        adQ_reg <= adS_reg;
    end

    assign cke = syncB_reg[6];
    assign cs_n = syncB_reg[5];
    assign ras_n = syncB_reg[4];
    assign cas_n = syncB_reg[3];
    assign we_n = syncB_reg[2];

    ////////////////////////////////////////////////////////////////
    // Command decode
    logic [2:0] cmd;
    logic isNop, isRd, isWr, isEmrsDll;
    assign cmd = {ras_n, cas_n, we_n};
    // Deselect ignores the strobes entirely
    assign isNop = cs_n || (cmd == sdcke_pkg::CMD_NOP);
    assign isRd = !cs_n && cmd == sdcke_pkg::CMD_READ;
    assign isWr = !cs_n && cmd == sdcke_pkg::CMD_WRITE;
    assign isEmrsDll = !cs_n && cmd == sdcke_pkg::CMD_MRS
        && baQ_reg == sdcke_pkg::BA_EMR
        && adQ_reg[sdcke_pkg::DLL_RST_BIT];

    ////////////////////////////////////////////////////////////////
    // State
    sdcke_pkg::sdcke_state_t state_reg, state_next;
    logic ckeQ_reg, ckeQ_next;
    logic lost_reg, lost_next;
    logic [2:0] burst_reg, burst_next;
    logic [1:0] waitCnt_reg, waitCnt_next;
    logic [7:0] lockCnt_reg, lockCnt_next;
    logic nop_reg, nop_next;
    logic activeOp;

    // Any operation that needs CKE held high
    assign activeOp = burst_reg != 3'h0 || !syncB_reg[0];

    always_comb
    begin
        state_next = state_reg;
        ckeQ_next = cke;
        lost_next = lost_reg;
        burst_next = burst_reg;
        waitCnt_next = waitCnt_reg;
        lockCnt_next = lockCnt_reg;
        nop_next = isNop;
        // NOP leaves a running burst counting down
        if (burst_reg != 3'h0)
            burst_next = burst_reg - 3'h1;
        else if ((isRd || isWr) && cke && state_reg == sdcke_pkg::ST_RUN)
            burst_next = sdcke_pkg::BURST_CYC_RST;
        unique case (state_reg)
            sdcke_pkg::ST_RUN:
            begin
                if (ckeQ_reg && !cke)
                begin
                    // Drop mid-operation is the async event
                    if (activeOp)
                    begin
                        lost_next = 1'b1;
                        state_next = sdcke_pkg::ST_LOST;
                        burst_next = 3'h0;
                    end
                    else if (isNop && syncB_reg[0])
                    begin
                        state_next = sdcke_pkg::ST_PWRDN;
                        waitCnt_next = 2'h0;
                    end
                end
            end
            sdcke_pkg::ST_PWRDN:
            begin
                if (waitCnt_reg != sdcke_pkg::FREQ_WAIT_CNT)
                    waitCnt_next = waitCnt_reg + 2'h1;
                if (cke)
                    state_next = sdcke_pkg::ST_RELOCK;
            end
            sdcke_pkg::ST_LOST:
            begin
                // Clocks must be stable before CKE returns
                if (cke)
                    state_next = sdcke_pkg::ST_REINIT;
            end
            sdcke_pkg::ST_REINIT:
            begin
                if (syncB_reg[1])
                begin
                    state_next = sdcke_pkg::ST_RUN;
                    lost_next = 1'b0;
                end
            end
            sdcke_pkg::ST_RELOCK:
            begin
                // Count starts at the DLL reset; only NOPs meanwhile
                if (isEmrsDll)
                    lockCnt_next = sdcke_pkg::DLL_LOCK_CNT;
                else if (lockCnt_reg > 8'h1)
                    lockCnt_next = lockCnt_reg - 8'h1;
                else if (lockCnt_reg == 8'h1)
                begin
                    lockCnt_next = 8'h0;
                    state_next = sdcke_pkg::ST_RUN;
                end
            end
            default:
                state_next = sdcke_pkg::ST_LOST;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_reg <= sdcke_pkg::ST_REINIT;
            ckeQ_reg <= 1'b0;
            lost_reg <= 1'b1;
            burst_reg <= 3'h0;
            waitCnt_reg <= 2'h0;
            lockCnt_reg <= 8'h0;
            nop_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ckeQ_reg <= ckeQ_next;
            lost_reg <= lost_next;
            burst_reg <= burst_next;
            waitCnt_reg <= waitCnt_next;
            lockCnt_reg <= lockCnt_next;
            nop_reg <= nop_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Registered outputs, one cycle after the state they show
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            dataLost <= 1'b1;
            ready <= 1'b0;
            pwrDown <= 1'b0;
            freqChangeOk <= 1'b0;
            dllLocked <= 1'b0;
            burstBusy <= 1'b0;
            nopSeen <= 1'b0;
        end
        else
        begin
            dataLost <= lost_reg;
            ready <= state_reg == sdcke_pkg::ST_RUN;
            pwrDown <= state_reg == sdcke_pkg::ST_PWRDN;
            freqChangeOk <= state_reg == sdcke_pkg::ST_PWRDN
                && waitCnt_reg == sdcke_pkg::FREQ_WAIT_CNT;
            // Re-init also resets the DLL, so no lock until it ends
            dllLocked <= state_reg == sdcke_pkg::ST_RUN
                || state_reg == sdcke_pkg::ST_PWRDN;
            burstBusy <= burst_reg != 3'h0;
            nopSeen <= nop_reg;
        end
    end

endmodule

// ==== sim/sdcke_tracker_sva.sv ====
// Purpose: Port checks for the tracker
// Assumes: One clock, sync reset
// Notes: Windows allow for synchronisers
`timescale 1ns/10ps
module sdcke_tracker_sva
(
    input wire logic sys_clk, // clk
    input wire logic resetn, // rst
    input wire logic ckePin, // pin
    input wire logic csN, // pin
    input wire logic rasN, // pin
    input wire logic casN, // pin
    input wire logic weN, // pin
    input wire logic dataLost, // out
    input wire logic ready, // out
    input wire logic pwrDown, // out
    input wire logic freqChangeOk, // out
    input wire logic dllLocked, // out
    input wire logic burstBusy, // out
    input wire logic nopSeen // out
);
//////////////////////////////
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    property p_lost; dataLost |-> !ready && !dllLocked; endproperty
    a_lost: assert property (p_lost) else $error("lost");
    property p_run; ready |-> dllLocked && !pwrDown; endproperty
    a_run: assert property (p_run) else $error("run");
    property p_fok; freqChangeOk |-> pwrDown; endproperty
    a_fok: assert property (p_fok) else $error("fok");
    property p_fw; $rose(pwrDown) ##1 pwrDown[*4] |-> freqChangeOk; endproperty
    a_fw: assert property (p_fw) else $error("fw");
    property p_bur; $rose(burstBusy) |-> burstBusy[*4]; endproperty
    a_bur: assert property (p_bur) else $error("burst");
    property p_nop; (!csN && rasN && casN && weN)[*6] |-> nopSeen; endproperty
    a_nop: assert property (p_nop) else $error("nop");
    property p_cmd; (!csN && !casN)[*6] |-> !nopSeen; endproperty
    a_cmd: assert property (p_cmd) else $error("cmd");
    property p_drop; $rose(burstBusy) && !ckePin |-> ##[1:6] dataLost; endproperty
    a_drop: assert property (p_drop) else $error("drop");
    c_pd: cover property ($rose(pwrDown));
    c_lk: cover property ($rose(dllLocked));
    c_ls: cover property ($rose(dataLost));
endmodule
bind sdcke_tracker sdcke_tracker_sva u_sva (.*);

// ==== sim/sdcke_ctrl_model.sv ====
// Purpose: Controller model on the pins
// Assumes: Pins move 1 ns after the edge
// Notes: Idle cycles carry NOP
`timescale 1ns/10ps
module sdcke_ctrl_model
(
    input wire logic sys_clk, // clk
    output logic ckePin, // CKE
    output logic csN, // pin
    output logic rasN, // pin
    output logic casN, // pin
    output logic weN, // pin
    output logic [1:0] bankAddr, // bank
    output logic [12:0] addr, // addr
    output logic initDone, // init
    output logic allBanksIdle // idle
);
//////////////////////////////
    // Clock never stops or retimes
    // No ODT pin: termination counts as off throughout
    initial
    begin
        {ckePin, csN, rasN, casN, weN} = 5'h17;
        bankAddr = 2'h0;
        addr = 13'h0000;
        initDone = 1'b0;
        allBanksIdle = 1'b1;
    end
    task send(logic [3:0] c, logic k, logic [1:0] b, logic [12:0] a, int n);
        @(posedge sys_clk) #1;
        {ckePin, csN, rasN, casN, weN} = {k, c};
        bankAddr = b;
        addr = a;
        repeat (n) @(posedge sys_clk);
        #1;
        {csN, rasN, casN, weN} = 4'h7;
    endtask
endmodule

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench
// Assumes: Model drives every pin
// Notes: Rows first, then power cases
`timescale 1ns/10ps
module testbench;
    logic sys_clk, resetn, ckePin, csN, rasN, casN, weN, initDone;
    logic allBanksIdle, dataLost, ready, pwrDown, freqChangeOk;
    logic dllLocked, burstBusy, nopSeen;
    logic [1:0] bankAddr;
    logic [12:0] addr;
    int err_total = 0;
    int num_checks = 0;
    int n;
    logic [4:0] rows [7] = '{5'h0a, 5'h08, 5'h02, 5'h04, 5'h0f, 5'h11, 5'h1f};
    wire logic [3:0] flags = {burstBusy, dataLost, freqChangeOk, ready};
    sdcke_tracker DUT (.*);
    sdcke_ctrl_model m (.*);
//////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task check(string nm, logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task waitfor(int w, int lim);
        for (n = 0; n < lim && flags[w] !== 1'b1; n++) @(posedge sys_clk) #1;
        if (n == lim)
        begin
            err_total++;
            finish_test();
        end
    endtask
    initial
    begin
        resetn = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        check("lost", dataLost, 1);
        check("dll", dllLocked, 0);
        m.initDone = 1'b1;
        waitfor(0, 20);
        check("lost", dataLost, 0);
        $display("reset done");
        foreach (rows[i])
        begin
            m.send(rows[i][4:1], 1'b1, 2'h0, 13'h0000, 6);
            check("nop", nopSeen, rows[i][0]);
        end
        $display("rows done");
        m.send({1'b0, sdcke_pkg::CMD_READ}, 1'b1, 2'h0, 13'h0000, 1);
        waitfor(3, 10);
        for (n = 0; burstBusy === 1'b1 && n < 9; n++) @(posedge sys_clk) #1;
        check("burst", n, sdcke_pkg::BURST_CYC_RST);
        // CKE low with ODT off
        m.send({1'b0, sdcke_pkg::CMD_NOP}, 1'b0, 2'h0, 13'h0000, 1);
        waitfor(1, 10);
        check("rdy", ready, 0);
        check("pd", pwrDown, 1);
        repeat (4) @(posedge sys_clk);
        m.send({1'b0, sdcke_pkg::CMD_NOP}, 1'b1, 2'h0, 13'h0000, 4);
        check("dll", dllLocked, 0);
        m.send(4'h0, 1'b1, sdcke_pkg::BA_MR, 13'h0000, 1);
        m.send(4'h0, 1'b1, sdcke_pkg::BA_EMR, 13'h0100, 1);
        waitfor(0, 300);
        check("lock", n >= 200 && n <= 208, 1);
        $display("freq change done");
        m.send({1'b0, sdcke_pkg::CMD_READ}, 1'b1, 2'h0, 13'h0000, 1);
        m.send({1'b0, sdcke_pkg::CMD_NOP}, 1'b0, 2'h0, 13'h0000, 1);
        waitfor(2, 12);
        m.initDone = 1'b0;
        m.send({1'b0, sdcke_pkg::CMD_NOP}, 1'b1, 2'h0, 13'h0000, 8);
        check("rdy", ready, 0);
        m.initDone = 1'b1;
        waitfor(0, 20);
        check("lost", dataLost, 0);
        $display("cke drop done");
        finish_test();
    end
endmodule
